// file: src/code_image_coherency_ctrl.sv
module code_image_coherency_ctrl #(
	parameter int DEPTH_W = code_coherency_pkg::DEPTH_W
) (
	// Clock and reset
	input  wire logic                                   ref_clk,
	input  wire logic                                   rst,
	// Operation issue from the execute stage
	input  code_coherency_pkg::mem_op_type              op,
	input  wire logic                                   op_valid,
	output logic                                        op_ready,
	// Interruption delivery and return
	input  wire logic                                   interruption,
	input  wire logic                                   interruption_return,
	// Memory system requests and visibility acknowledges
	output code_coherency_pkg::mem_op_type              mem_req,
	output logic                                        mem_req_valid,
	input  wire logic                                   mem_req_ready,
	input  wire logic                                   store_visible,
	input  wire logic                                   flush_visible,
	// Instruction cache invalidation
	output logic                                        icache_inval,
	output logic [code_coherency_pkg::ADDR_W-1:0]       icache_inval_line,
	// Branch retirement check
	input  code_coherency_pkg::branch_retire_type       branch,
	output logic                                        branch_retire_ok,
	// Pipeline control
	output logic                                        pipe_flush,
	output logic [code_coherency_pkg::ADDR_W-1:0]       refetch_addr,
	input  wire logic [code_coherency_pkg::ADDR_W-1:0]  next_fetch_ip,
	// Status
	output logic                                        sync_pending
);
	if (DEPTH_W < 1) begin : g_depth_check
		$error("code_image_coherency_ctrl: DEPTH_W too small");
	end

	localparam int AW = code_coherency_pkg::ADDR_W;

	typedef enum logic [1:0] {
		SER_IDLE,
		SER_WAIT_SYNC,
		SER_RESTART
	} ser_state_type;

	ser_state_type ser_q;
	logic          sync_wait_q;
	logic          fence_wait_q;
	logic          ser_ip_ld;
	logic [AW-1:0] ser_ip_q;
	logic          stores_idle;
	logic          stores_full;
	logic          flushes_idle;
	logic          flushes_full;
	logic          mem_fire;
	logic          op_take;
	logic          issue_store;
	logic          issue_flush;
	logic          blocked;
	logic          mismatch;
	logic          self_correct;

	code_coherency_pkg::op_kind_type kind;
	assign kind = op.kind;

	// Stores and flushes are tracked apart: a stream sync cares only for flushes.
	outstanding_counter #(.WIDTH(DEPTH_W)) store_track (
		.ref_clk (ref_clk),
		.rst     (rst),
		.issue   (issue_store),
		.done    (store_visible),
		.idle    (stores_idle),
		.full    (stores_full)
	);

	outstanding_counter #(.WIDTH(DEPTH_W)) flush_track (
		.ref_clk (ref_clk),
		.rst     (rst),
		.issue   (issue_flush),
		.done    (flush_visible),
		.idle    (flushes_idle),
		.full    (flushes_full)
	);

	// Plain stores go to memory only; no instruction cache line is touched. [RULE_01]
	// Whole aligned units pass in one request so fetch never sees a torn value. [RULE_14]
	always_comb begin
		blocked = 1'b0;
		case (kind)
			code_coherency_pkg::OP_STORE: begin
				blocked = stores_full;
			end
			code_coherency_pkg::OP_LINE_FLUSH: begin
				blocked = flushes_full;
			end
			code_coherency_pkg::OP_RELEASE_STORE: begin
				// Earlier stores and flushes must be visible first. [RULE_07] [RULE_08]
				// A sync still waiting also holds it, being orderable. [RULE_16]
				blocked = stores_full || !stores_idle || !flushes_idle || sync_wait_q;
			end
			code_coherency_pkg::OP_MEMORY_FENCE: begin
				blocked = sync_wait_q || fence_wait_q; // [RULE_16] [RULE_12]
			end
			code_coherency_pkg::OP_SERIALIZE: begin
				blocked = (ser_q != SER_IDLE); // [RULE_05]
			end
			default: begin
				blocked = 1'b0;
			end
		endcase
	end

	assign op_ready = op_valid && !blocked && (ser_q == SER_IDLE)
		&& (mem_req_ready || kind == code_coherency_pkg::OP_STREAM_SYNC
			|| kind == code_coherency_pkg::OP_SERIALIZE
			|| kind == code_coherency_pkg::OP_MEMORY_FENCE
			|| kind == code_coherency_pkg::OP_NONE);
	assign op_take  = op_valid && op_ready;

	assign mem_req_valid = op_valid && !blocked && (ser_q == SER_IDLE)
		&& (kind == code_coherency_pkg::OP_STORE
			|| kind == code_coherency_pkg::OP_RELEASE_STORE
			|| kind == code_coherency_pkg::OP_LINE_FLUSH);
	assign mem_req  = op;
	assign mem_fire = mem_req_valid && mem_req_ready;

	assign issue_store = mem_fire && (kind == code_coherency_pkg::OP_STORE
		|| kind == code_coherency_pkg::OP_RELEASE_STORE);
	assign issue_flush = mem_fire && (kind == code_coherency_pkg::OP_LINE_FLUSH);

	// Invalidation covers the whole line, hence both instructions in it. [RULE_02] [RULE_03]
	// A later fetch of that line then misses and refills from memory. [RULE_17]
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			icache_inval      <= 1'b0;
			icache_inval_line <= '0;
		end else begin
			icache_inval      <= issue_flush;
			icache_inval_line <= {op.addr[AW-1:code_coherency_pkg::LINE_OFS_W],
				{code_coherency_pkg::LINE_OFS_W{1'b0}}};
		end
	end

	// The sync holds until every earlier flush is visible. [RULE_04]
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			sync_wait_q <= 1'b0;
		end else if (op_take && kind == code_coherency_pkg::OP_STREAM_SYNC) begin
			sync_wait_q <= !flushes_idle;
		end else if (flushes_idle) begin
			sync_wait_q <= 1'b0;
		end
	end

	// The fence drains stores too, so remotes see the patched branch. [RULE_12]
	// Without it nothing is forced; updates drain on their own. [RULE_13]
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			fence_wait_q <= 1'b0;
		end else if (op_take && kind == code_coherency_pkg::OP_MEMORY_FENCE) begin
			fence_wait_q <= !(stores_idle && flushes_idle);
		end else if (stores_idle && flushes_idle) begin
			fence_wait_q <= 1'b0;
		end
	end

	assign sync_pending = sync_wait_q;

	// Serialization: wait for the sync, then flush and refetch. [RULE_05] [RULE_06]
	// Held instructions are not snooped; only this restarts them. [RULE_15]
	assign ser_ip_ld = (ser_q == SER_IDLE) && (interruption || interruption_return
		|| (op_take && kind == code_coherency_pkg::OP_SERIALIZE));

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			ser_q <= SER_IDLE;
		end else begin
			case (ser_q)
				SER_IDLE: begin
					if (ser_ip_ld) begin
						ser_q <= SER_WAIT_SYNC; // [RULE_06]
					end
				end
				SER_WAIT_SYNC: begin
					if (!sync_wait_q) begin
						ser_q <= SER_RESTART;
					end
				end
				SER_RESTART: begin
					ser_q <= SER_IDLE;
				end
				default: begin
					ser_q <= SER_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			ser_ip_q <= '0;
		end else if (ser_ip_ld) begin
			ser_ip_q <= next_fetch_ip;
		end
	end

	// Version mix shows as a target mismatch; only taken relative branches count. [RULE_11]
	assign self_correct = branch.valid && branch.is_branch && branch.taken
		&& branch.ip_relative;
	assign mismatch = self_correct && (branch.actual_target != branch.predicted_target);

	// Matching versions retire with no flush. [RULE_10]
	assign branch_retire_ok = branch.valid && !mismatch;

	// Mixed versions flush before retirement and refetch the real target. [RULE_09]
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			pipe_flush   <= 1'b0;
			refetch_addr <= '0;
		end else if (mismatch) begin
			pipe_flush   <= 1'b1;
			refetch_addr <= branch.actual_target;
		end else if (ser_q == SER_RESTART) begin
			pipe_flush   <= 1'b1; // [RULE_05]
			refetch_addr <= ser_ip_q;
		end else begin
			pipe_flush   <= 1'b0;
			refetch_addr <= refetch_addr;
		end
	end
endmodule : code_image_coherency_ctrl

// file: src/code_coherency_pkg.sv
// Function
// [RULE_01] Data stores never touch instruction cache.
// [RULE_02] Line flush invalidates all lines holding address.
// [RULE_03] 16-byte instructions; one line covers two.
// [RULE_04] Stream sync waits for earlier flushes.
// [RULE_05] Serialize waits sync, then refetches younger groups.
// [RULE_06] Interruption and return act as serialize.
// [RULE_07] Release store waits earlier stores, flushes visible.
// [RULE_08] Release branch seen implies coherent cache.
// [RULE_09] Mixed-version branch and target forces flush.
// [RULE_10] Same-version branch and target retires normally.
// [RULE_11] Self-correction only for taken relative branches.
// [RULE_12] Flush, sync, fence make remotes fetch new.
// [RULE_13] Without trailer, remotes see updates eventually.
// [RULE_14] Aligned stores seen atomically by fetch.
// [RULE_15] Pipeline not snooped; remote serializes itself.
// [RULE_16] Stream sync obeys later release or fence.
// [RULE_17] Fetch of invalidated line misses, refills.
package code_coherency_pkg;
	localparam int INSN_BYTES       = 16;
	localparam int INSNS_PER_LINE   = 2;
	localparam int LINE_BYTES       = INSN_BYTES * INSNS_PER_LINE;
	localparam int ADDR_W           = 32;
	localparam int INSN_W           = INSN_BYTES * 8;
	localparam int LINE_OFS_W       = $clog2(LINE_BYTES);
	localparam int INSN_OFS_W       = $clog2(INSN_BYTES);
	localparam int DEPTH_W          = 4;

	typedef enum logic [2:0] {
		OP_NONE,
		OP_STORE,
		OP_RELEASE_STORE,
		OP_LINE_FLUSH,
		OP_STREAM_SYNC,
		OP_SERIALIZE,
		OP_MEMORY_FENCE
	} op_kind_type;

	typedef struct packed {
		op_kind_type             kind;
		logic [ADDR_W-1:0]       addr;
		logic [INSN_W-1:0]       data;
	} mem_op_type;

	typedef struct packed {
		logic                    valid;
		logic                    is_branch;
		logic                    taken;
		logic                    ip_relative;
		logic [ADDR_W-1:0]       actual_target;
		logic [ADDR_W-1:0]       predicted_target;
	} branch_retire_type;
endpackage : code_coherency_pkg

// file: src/outstanding_counter.sv
// Counts issued operations that the memory system has not yet acknowledged.
module outstanding_counter #(
	parameter int WIDTH = 4
) (
	// Clock and reset
	input  wire logic             ref_clk,
	input  wire logic             rst,
	// Events
	input  wire logic             issue,
	input  wire logic             done,
	// Status
	output logic                  idle,
	output logic                  full
);
	// A counter needs at least one bit; refuse the instance before it is built.
	if (WIDTH < 1) begin : g_width_check
		$error("outstanding_counter: WIDTH too small");
	end

	logic [WIDTH-1:0] count_q;

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			count_q <= '0;
		end else if (issue && !done) begin
			count_q <= count_q + WIDTH'(1);
		end else if (done && !issue && count_q != '0) begin
			count_q <= count_q - WIDTH'(1);
		end
	end

	assign idle = (count_q == '0);
	assign full = (count_q == {WIDTH{1'b1}});
endmodule : outstanding_counter

// file: verif/mem_partner.sv
module mem_partner (
	// Clock and reset
	input wire logic                      ref_clk,
	input wire logic                      rst,
	// Requests and pacing
	input code_coherency_pkg::mem_op_type mem_req,
	input wire logic                      mem_req_valid,
	output logic                          mem_req_ready,
	input wire logic [1:0]                stall,
	// Visibility acknowledges
	output logic                          store_visible,
	output logic                          flush_visible
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [3:0] stores_q;
	logic [3:0] flushes_q;
	wire take = mem_req_valid && mem_req_ready;
	wire is_flush = mem_req.kind == code_coherency_pkg::OP_LINE_FLUSH;
	assign mem_req_ready = !stall[0];
	// Stores drain before flushes, so a flush waits behind every pending store, even one issued after it.
	assign store_visible = stores_q != 4'h0 && !stall[1];
	assign flush_visible = flushes_q != 4'h0 && stores_q == 4'h0 && !stall[1];
	always_ff @(posedge ref_clk) begin
		if (rst) stores_q <= 4'h0;
		else stores_q <= stores_q + 4'(take && !is_flush) - 4'(store_visible);
	end
	always_ff @(posedge ref_clk) begin
		if (rst) flushes_q <= 4'h0;
		else flushes_q <= flushes_q + 4'(take && is_flush) - 4'(flush_visible);
	end
endmodule : mem_partner

// file: verif/code_image_coherency_ctrl_checker.sv
module code_image_coherency_ctrl_checker (
	// Clock and reset
	input wire logic                             ref_clk,
	input wire logic                             rst,
	// Watched ports
	input code_coherency_pkg::mem_op_type        op,
	input wire logic                             op_valid,
	input wire logic                             op_ready,
	input wire logic                             icache_inval,
	input wire logic [31:0]                      icache_inval_line,
	input code_coherency_pkg::branch_retire_type branch,
	input wire logic                             branch_retire_ok,
	input wire logic                             pipe_flush,
	input wire logic                             flush_visible,
	input wire logic                             sync_pending
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	wire take = op_valid && op_ready;
	wire same = branch.actual_target == branch.predicted_target;
	wire mis = branch.valid && branch.is_branch && branch.taken && branch.ip_relative && !same;
	sequence flush_take; take && op.kind == code_coherency_pkg::OP_LINE_FLUSH; endsequence
	sequence sync_take; take && op.kind == code_coherency_pkg::OP_STREAM_SYNC; endsequence
	sequence ser_take; take && op.kind == code_coherency_pkg::OP_SERIALIZE; endsequence
	a_flush_inval: assert property (flush_take |=> icache_inval
		&& icache_inval_line == {$past(op.addr[31:5]), 5'h00}) else $error("no invalidate");
	a_inval_cause: assert property (icache_inval |->
		$past(take && op.kind == code_coherency_pkg::OP_LINE_FLUSH)) else $error("stray inval");
	a_line_aligned: assert property (icache_inval |->
		icache_inval_line[4:0] == 5'h00) else $error("line not aligned");
	a_sync_waits: assert property (flush_take ##1 (sync_take and !flush_visible)
		|=> sync_pending) else $error("sync did not wait");
	a_release_held: assert property (sync_pending |->
		!(take && op.kind == code_coherency_pkg::OP_RELEASE_STORE)) else $error("early release");
	a_mis_flush: assert property (mis |=> pipe_flush) else $error("no flush");
	a_mis_refused: assert property (mis |-> !branch_retire_ok)
		else $error("mismatch retired");
	a_same_retire: assert property (branch.valid && same |-> branch_retire_ok)
		else $error("same version refused");
	a_ser_restart: assert property (ser_take ##1 !sync_pending |-> ##[1:3] pipe_flush)
		else $error("no restart");
endmodule : code_image_coherency_ctrl_checker
bind code_image_coherency_ctrl code_image_coherency_ctrl_checker checker_inst (.ref_clk, .rst,
	.op, .op_valid, .op_ready, .icache_inval, .icache_inval_line, .branch, .branch_retire_ok,
	.pipe_flush, .flush_visible, .sync_pending);

// file: verif/tb.sv
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic ref_clk = 1'b0, rst = 1'b1, op_valid = 1'b0, interruption = 1'b0;
	logic interruption_return = 1'b0, freeze = 1'b0;
	logic op_ready, mem_req_valid, mem_req_ready, store_visible, flush_visible, icache_inval;
	logic branch_retire_ok, pipe_flush, sync_pending;
	logic [31:0] next_fetch_ip = 32'h0, refetch_addr, icache_inval_line;
	logic [1:0] stall = 2'h0;
	logic [15:0] lfsr_q = 16'hCD42;
	code_coherency_pkg::mem_op_type op = '0;
	code_coherency_pkg::mem_op_type mem_req;
	code_coherency_pkg::branch_retire_type branch = '0;
	int n_mismatch = 0, checks = 0;
	code_image_coherency_ctrl code_image_coherency_ctrl_inst (.ref_clk, .rst, .op, .op_valid,
		.op_ready, .interruption, .interruption_return, .mem_req, .mem_req_valid, .mem_req_ready,
		.store_visible, .flush_visible, .icache_inval, .icache_inval_line, .branch,
		.branch_retire_ok, .pipe_flush, .refetch_addr, .next_fetch_ip, .sync_pending);
	mem_partner mem_partner_inst (.ref_clk, .rst, .mem_req, .mem_req_valid, .mem_req_ready,
		.stall, .store_visible, .flush_visible);
	function automatic logic [15:0] lfsr();
		lfsr_q = {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
		return lfsr_q;
	endfunction : lfsr
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : tally_and_finish
	// Leaves op_valid high so that callers can issue back to back.
	task automatic do_op(input code_coherency_pkg::op_kind_type k, input logic [31:0] a);
		int i;
		logic mem_kind;
		mem_kind = k inside {code_coherency_pkg::OP_STORE, code_coherency_pkg::OP_RELEASE_STORE,
			code_coherency_pkg::OP_LINE_FLUSH};
		op = '{kind: k, addr: a, data: {8{lfsr()}}};
		op_valid = 1'b1;
		for (i = 0; i < 200; i++) begin
			#10;
			if (op_ready === 1'b1) break;
			@(negedge ref_clk);
		end
		if (i < 200) begin
			check(32'(mem_req_valid), 32'(mem_kind));
			check(mem_req.addr, a);
			check(mem_req.data[127:96], op.data[127:96]);
		end
		@(negedge ref_clk);
		if (i == 200) n_mismatch++;
	endtask : do_op
	always #50 ref_clk = ~ref_clk;
	always @(negedge ref_clk) stall <= 2'(lfsr() >> 7) | {freeze, 1'b0};
	initial begin
		#500000;
		n_mismatch++;
		tally_and_finish();
	end
	initial begin
		int i, j;
		code_coherency_pkg::op_kind_type k;
		logic [31:0] a, t, p;
		logic tk, rel, mis;
		repeat (8) @(negedge ref_clk);
		rst = 1'b0;
		check(32'(icache_inval | pipe_flush | sync_pending), 32'h0);
		for (i = 0; i < 9; i++) begin
			k = code_coherency_pkg::op_kind_type'(3'(1 + i % 3));
			a = {lfsr(), lfsr()} & 32'hFFFF_FFF0;
			do_op(k, a);
			check(32'(icache_inval), 32'(k == code_coherency_pkg::OP_LINE_FLUSH));
			if (icache_inval === 1'b1) check(icache_inval_line, a & 32'hFFFF_FFE0);
		end
		do_op(code_coherency_pkg::OP_MEMORY_FENCE, 32'h0);
		freeze = 1'b1;
		do_op(code_coherency_pkg::OP_LINE_FLUSH, 32'h0000_1040);
		do_op(code_coherency_pkg::OP_STREAM_SYNC, 32'h0);
		op = '{kind: code_coherency_pkg::OP_RELEASE_STORE, addr: 32'h0000_2000, data: '0};
		repeat (3) @(negedge ref_clk);
		check(32'(sync_pending), 32'h1);
		check(32'(op_ready), 32'h0);
		op.kind = code_coherency_pkg::OP_MEMORY_FENCE;
		#10 check(32'(op_ready), 32'h0);
		@(negedge ref_clk);
		op_valid = 1'b0;
		freeze = 1'b0;
		for (i = 0; i < 100 && sync_pending !== 1'b0; i++) @(negedge ref_clk);
		check(32'(sync_pending), 32'h0);
		do_op(code_coherency_pkg::OP_RELEASE_STORE, 32'h0000_2000);
		op_valid = 1'b0;
		for (i = 0; i < 3; i++) begin
			@(negedge ref_clk);
			next_fetch_ip = {lfsr(), lfsr()} & 32'hFFFF_FFF0;
			if (i == 0) do_op(code_coherency_pkg::OP_SERIALIZE, 32'h0);
			else {interruption, interruption_return} = (i == 1) ? 2'h2 : 2'h1;
			op_valid = 1'b0;
			@(negedge ref_clk);
			{interruption, interruption_return} = 2'h0;
			for (j = 0; j < 10 && pipe_flush !== 1'b1; j++) @(negedge ref_clk);
			check(32'(pipe_flush), 32'h1);
			check(refetch_addr, next_fetch_ip);
		end
		for (i = 0; i < 24; i++) begin
			t = {lfsr(), lfsr()};
			p = lfsr() > 16'h7FFF ? t : t ^ 32'h0000_0010;
			// Mostly taken relative branches, with some that may not self-correct.
			tk = lfsr() > 16'h3FFF;
			rel = lfsr() > 16'h3FFF;
			mis = tk && rel && (t != p);
			branch = '{1'b1, 1'b1, tk, rel, t, p};
			#10 check(32'(branch_retire_ok), 32'(!mis));
			@(negedge ref_clk);
			branch.valid = 1'b0;
			check(32'(pipe_flush), 32'(mis));
			if (mis) check(refetch_addr, t);
			@(negedge ref_clk);
		end
		tally_and_finish();
	end
endmodule : tb
